// ===== hw/pild_lamp_driver.sv
// per-port driver of three indicator lamps with an apb config register
// assumes phy status pins are asynchronous; one core clock domain
//
// Contract
// - lamp A selector bits 15:12, reset speed
// - codes 1-3 show tx, rx, collision stretched
// - codes 4, 5 show link, duplex continuously
// - code 7 shows rx or tx activity
// - code 8 forces on, 9 off
// - codes A, B blink fast, slow
// - combined: primary solid, secondary toggles lamp
// - code D is link plus activity
// - code E is duplex plus collision
// - lamp B selector bits 11:8, reset link
// - lamp C selector bits 7:4, reset receive
// - bits 3:2 pick 30, 60, 100 ms
// - bit 1 enables stretching, reset one
// - combined codes always stretched
// - duplex lamp may lag link loss briefly
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module pild_lamp_driver #(
  parameter pild_pkg::pild_cnt_t STR_SHORT = pild_pkg::STR_SHORT_CYC,
  parameter pild_pkg::pild_cnt_t STR_MID   = pild_pkg::STR_MID_CYC,
  parameter pild_pkg::pild_cnt_t STR_LONG  = pild_pkg::STR_LONG_CYC,
  parameter pild_pkg::pild_cnt_t FAST_HALF = pild_pkg::FAST_HALF_CYC,
  parameter pild_pkg::pild_cnt_t SLOW_HALF = pild_pkg::SLOW_HALF_CYC
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [pild_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire pild_pkg::pild_phy_s        phyIn,
  output logic      [pild_pkg::LAMPS-1:0] lampOut
);
  import pild_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [CFG_W-1:0] cfg_r;         // lamp configuration register
  logic [31:0]      prdata_r;      // read data
  logic             pready_r;      // access-phase ready
  logic             pslverr_r;     // unmapped address
  pild_phy_s        phyMeta_r;     // first sync stage
  pild_phy_s        phySync_r;     // second sync stage
  pild_cnt_t        fastCnt_r;     // fast blink divider
  pild_cnt_t        slowCnt_r;     // slow blink divider
  logic             fastBlink_r;   // fast square wave
  logic             slowBlink_r;   // slow square wave
  logic [LAMPS-1:0] lamp_r;        // lamp drive
  logic [LAMPS-1:0] lamp_nxt;      // next lamp drive
  logic [LAMPS-1:0] strAct;        // stretcher busy, per lamp
  logic [LAMPS-1:0] strEvt;        // stretcher trigger, per lamp
  logic [LAMPS-1:0] strUse;        // stretching applies, per lamp
  pild_cnt_t        lenCyc;        // chosen stretch length
  logic             setupHit;      // setup cycle of a transfer
  logic             accessDone;    // access completes at this edge
  logic             addrHit;       // config register addressed

  // ****************************************
  // functions
  // ****************************************
  // selector field of one lamp
  function automatic pild_src_e srcOf(input logic [CFG_W-1:0] c,
                                      input int idx);
    logic [3:0] f;
    f = 4'h0;
    case (idx)
      0:       f = c[LAMP_A_LSB +: 4];
      1:       f = c[LAMP_B_LSB +: 4];
      default: f = c[LAMP_C_LSB +: 4];
    endcase
    return pild_src_e'(f);
  endfunction

  // true for the combined primary/secondary codes
  function automatic logic isCombined(input pild_src_e s);
    return (s == SRC_LNKRX) || (s == SRC_LNKACT) || (s == SRC_DUPCOL);
  endfunction

  // raw event that a code stretches
  function automatic logic evtOf(input pild_src_e s,
                                 input pild_phy_s p);
    logic e;
    e = 1'b0;
    case (s)
      SRC_TX:     e = p.txAct;
      SRC_RX:     e = p.rxAct;
      SRC_COL:    e = p.collision;
      SRC_ACT:    e = p.txAct | p.rxAct;
      SRC_LNKRX:  e = p.rxAct | p.isolate;
      SRC_LNKACT: e = p.txAct | p.rxAct;
      SRC_DUPCOL: e = p.collision;
      default:    e = 1'b0;
    endcase
    return e;
  endfunction

  // lamp level for one code
  function automatic logic lampOf(input pild_src_e s,
                                  input pild_phy_s p,
                                  input logic      act,
                                  input logic      strOn,
                                  input logic      fast,
                                  input logic      slow);
    logic v;
    v = 1'b0;
    case (s)
      SRC_SPEED:  v = p.speed100;
      SRC_TX,
      SRC_RX,
      SRC_COL,
      SRC_ACT:    v = strOn ? act : evtOf(s, p);
      SRC_LINK:   v = p.link;
      SRC_DUPLEX: v = p.fullDuplex;
      SRC_ON:     v = 1'b1;
      SRC_OFF:    v = 1'b0;
      SRC_FAST:   v = fast;
      SRC_SLOW:   v = slow;
      SRC_LNKRX:  v = p.link ^ act;
      SRC_LNKACT: v = p.link ^ act;
      SRC_DUPCOL: v = p.fullDuplex ^ act;
      default:    v = 1'b0;
    endcase
    return v;
  endfunction

  // ****************************************
  // apb slave
  // ****************************************
  assign setupHit   = psel && !penable;
  assign accessDone = psel && penable && pready_r;
  assign addrHit    = (paddr == CFG_OFFSET);

  // ready one cycle after setup, for one cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setupHit;
    end
  end

  // error flag for any address but the config word
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= setupHit && !addrHit;
    end
  end

  // read data captured at setup; zero when unmapped
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setupHit && !pwrite && addrHit) begin
      prdata_r <= {16'h0000, cfg_r};
    end else if (setupHit) begin
      prdata_r <= 32'h0000_0000;
    end
  end

  // ****************************************
  // configuration register
  // ****************************************
  // reset and write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= CFG_RESET;
    end else if (accessDone && pwrite && addrHit) begin
      cfg_r <= pwdata[CFG_W-1:0];
    end
  end

  // ****************************************
  // phy status synchroniser
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      phyMeta_r <= '0;
      phySync_r <= '0;
    end else begin
      phyMeta_r <= phyIn;
      phySync_r <= phyMeta_r;
    end
  end

  // ****************************************
  // test blink dividers
  // ****************************************
  // fast divider
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fastCnt_r   <= '0;
      fastBlink_r <= 1'b0;
    end else if (fastCnt_r >= FAST_HALF - pild_cnt_t'(1)) begin
      fastCnt_r   <= '0;
      fastBlink_r <= !fastBlink_r;
    end else begin
      fastCnt_r <= fastCnt_r + pild_cnt_t'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slowCnt_r   <= '0;
      slowBlink_r <= 1'b0;
    end else if (slowCnt_r >= SLOW_HALF - pild_cnt_t'(1)) begin
      slowCnt_r   <= '0;
      slowBlink_r <= !slowBlink_r;
    end else begin
      slowCnt_r <= slowCnt_r + pild_cnt_t'(1);
    end
  end

  // ****************************************
  // stretch length
  // ****************************************
  // length decode
  always_comb begin
    case (cfg_r[LEN_LSB +: 2])
      2'h0:    lenCyc = STR_SHORT;
      2'h1:    lenCyc = STR_MID;
      default: lenCyc = STR_LONG;  // reserved code acts as longest
    endcase
  end

  // ****************************************
  // per-lamp logic
  // ****************************************
  for (genvar i = 0; i < LAMPS; i++) begin : g_lamp
    pild_src_e src;  // this lamp's selector
    assign src = srcOf(cfg_r, i);
    assign strUse[i] = cfg_r[STR_EN_BIT] || isCombined(src);
    assign strEvt[i] = strUse[i] && evtOf(src, phySync_r);

    pild_stretch u_stretch (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .evt     (strEvt[i]),
      .lenCyc  (lenCyc),
      .active  (strAct[i])
    );

    assign lamp_nxt[i] = lampOf(src, phySync_r, strAct[i], strUse[i],
                                fastBlink_r, slowBlink_r);

    property p_forceOn;
      @(posedge clk_sys) disable iff (!rstn)
        (src == SRC_ON) |=> lamp_r[i];
    endproperty
    a_forceOn: assert property (p_forceOn)
      else $error("forced-on lamp dark");

    property p_forceOff;
      @(posedge clk_sys) disable iff (!rstn)
        (src == SRC_OFF) |=> !lamp_r[i];
    endproperty
    a_forceOff: assert property (p_forceOff)
      else $error("forced-off lamp lit");

    property p_linkShow;
      @(posedge clk_sys) disable iff (!rstn)
        (src == SRC_LINK) |=> lamp_r[i] == $past(phySync_r.link);
    endproperty
    a_linkShow: assert property (p_linkShow)
      else $error("link lamp wrong");

    property p_speedShow;
      @(posedge clk_sys) disable iff (!rstn)
        (src == SRC_SPEED) |=> lamp_r[i] == $past(phySync_r.speed100);
    endproperty
    a_speedShow: assert property (p_speedShow)
      else $error("speed lamp wrong");

    property p_rawRx;
      @(posedge clk_sys) disable iff (!rstn)
        (src == SRC_RX && !cfg_r[STR_EN_BIT])
          |=> lamp_r[i] == $past(phySync_r.rxAct);
    endproperty
    a_rawRx: assert property (p_rawRx)
      else $error("raw receive lamp wrong");

    // stretched transmit lights two cycles on
    sequence s_txSeen;
      src == SRC_TX && cfg_r[STR_EN_BIT] && phySync_r.txAct;
    endsequence
    sequence s_txHeld;
      src == SRC_TX && cfg_r[STR_EN_BIT];
    endsequence
    property p_txStretch;
      @(posedge clk_sys) disable iff (!rstn)
        s_txSeen ##1 s_txHeld |=> lamp_r[i];
    endproperty
    a_txStretch: assert property (p_txStretch)
      else $error("stretched transmit lamp dark");

    // combined codes trigger even with stretching off
    property p_combForce;
      @(posedge clk_sys) disable iff (!rstn)
        (src == SRC_DUPCOL && phySync_r.collision) |=> strAct[i];
    endproperty
    a_combForce: assert property (p_combForce)
      else $error("combined code not stretched");

    property p_dupIdle;
      @(posedge clk_sys) disable iff (!rstn)
        (src == SRC_DUPCOL && !strAct[i])
          |=> lamp_r[i] == $past(phySync_r.fullDuplex);
    endproperty
    a_dupIdle: assert property (p_dupIdle)
      else $error("duplex combined lamp wrong");
  end

  // ****************************************
  // lamp output flops
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lamp_r <= '0;
    end else begin
      lamp_r <= lamp_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign lampOut = lamp_r;

  property p_cfgWrite;
    @(posedge clk_sys) disable iff (!rstn)
      (accessDone && pwrite && addrHit)
        |=> cfg_r == $past(pwdata[CFG_W-1:0]);
  endproperty
  a_cfgWrite: assert property (p_cfgWrite)
    else $error("config write lost");

  // fast blink holds steady the cycle after its count restarts
  property p_fastBlink;
    @(posedge clk_sys) disable iff (!rstn)
      (fastCnt_r == '0) |=> $stable(fastBlink_r);
  endproperty
  a_fastBlink: assert property (p_fastBlink)
    else $error("fast blink toggled early");

endmodule // pild_lamp_driver
`default_nettype wire

// ===== hw/pild_pkg.sv
// constants, types and register layout of the lamp driver
// assumes a 100 MHz core clock and a 32-bit APB register bus
package pild_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int          ADDR_W     = 12;         // apb address width
  localparam int          CFG_W      = 16;         // config width
  localparam logic [11:0] CFG_OFFSET = 12'h014;    // config byte address
  localparam logic [15:0] CFG_RESET  = 16'h0422;   // A=0,B=4,C=2,en=1

  // ****************************************
  // field positions
  // ****************************************
  localparam int LAMP_A_LSB  = 12;  // lamp_a_source_select
  localparam int LAMP_B_LSB  = 8;   // lamp_b_source_select
  localparam int LAMP_C_LSB  = 4;   // lamp_c_source_select
  localparam int LEN_LSB     = 2;   // stretch_length_select
  localparam int STR_EN_BIT  = 1;   // global stretch enable
  localparam int LAMPS       = 3;   // lamp outputs per port

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_KHZ      = 100000;  // core clock in kHz
  localparam int STR_SHORT_MS = 30;      // length code 00
  localparam int STR_MID_MS   = 60;      // length code 01
  localparam int STR_LONG_MS  = 100;     // length code 10
  localparam int BLINK_FAST_HZ = 10;     // fast test blink
  localparam int BLINK_SLOW_HZ = 2;      // slow test blink
  localparam int CNT_W         = 25;     // holds the longest count

  typedef logic [CNT_W-1:0] pild_cnt_t;  // cycle counter

  // counts cut to the counter width on purpose; all of them fit
  localparam pild_cnt_t STR_SHORT_CYC = pild_cnt_t'(STR_SHORT_MS * CLK_KHZ);
  localparam pild_cnt_t STR_MID_CYC   = pild_cnt_t'(STR_MID_MS * CLK_KHZ);
  localparam pild_cnt_t STR_LONG_CYC  = pild_cnt_t'(STR_LONG_MS * CLK_KHZ);
  localparam pild_cnt_t FAST_HALF_CYC =
    pild_cnt_t'((CLK_KHZ * 1000) / (2 * BLINK_FAST_HZ));
  localparam pild_cnt_t SLOW_HALF_CYC =
    pild_cnt_t'((CLK_KHZ * 1000) / (2 * BLINK_SLOW_HZ));

  // ****************************************
  // lamp source codes
  // ****************************************
  typedef enum logic [3:0] {
    SRC_SPEED  = 4'h0,
    SRC_TX     = 4'h1,
    SRC_RX     = 4'h2,
    SRC_COL    = 4'h3,
    SRC_LINK   = 4'h4,
    SRC_DUPLEX = 4'h5,
    SRC_RSV6   = 4'h6,
    SRC_ACT    = 4'h7,
    SRC_ON     = 4'h8,
    SRC_OFF    = 4'h9,
    SRC_FAST   = 4'hA,
    SRC_SLOW   = 4'hB,
    SRC_LNKRX  = 4'hC,
    SRC_LNKACT = 4'hD,
    SRC_DUPCOL = 4'hE,
    SRC_RSVF   = 4'hF
  } pild_src_e;

  // ****************************************
  // port status carried from the phy
  // ****************************************
  typedef struct packed {
    logic link;        // link up
    logic speed100;    // 100 Mb/s
    logic fullDuplex;  // full duplex
    logic collision;   // collision seen
    logic txAct;       // transmitting
    logic rxAct;       // receiving
    logic isolate;     // port isolated
  } pild_phy_s;

endpackage

// ===== hw/pild_stretch.sv
// one pulse stretcher: holds its output for a chosen count
// assumes the event is already on the core clock
`timescale 1ns/10ps
`default_nettype none
module pild_stretch (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             evt,
  input  wire pild_pkg::pild_cnt_t lenCyc,
  output logic                  active
);
  import pild_pkg::*;

  pild_cnt_t cnt_r;  // cycles left in the interval

  // ****************************************
  // counter
  // ****************************************
  // restart on event
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (evt) begin
      // any new event reloads the full length
      cnt_r <= lenCyc;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - pild_cnt_t'(1);
    end
  end

  // on while cycles remain
  assign active = (cnt_r != '0);

  property p_holdLen;
    @(posedge clk_sys) disable iff (!rstn)
      evt |=> (cnt_r == $past(lenCyc)) && active;
  endproperty
  a_holdLen: assert property (p_holdLen)
    else $error("stretch not reloaded");

endmodule // pild_stretch
`default_nettype wire

// ===== verification/pild_lamp_driver_tb.sv
// testbench of the lamp driver: apb master, phy stimulus, lamp model
// assumes the shortened stretch and blink counts set below
`timescale 1ns/10ps
`default_nettype none
module pild_lamp_driver_tb;
  import pild_pkg::*;
  // ****************************************
  // settings and signals
  // ****************************************
  localparam int SH    = 20;     // short stretch
  localparam int MD    = 40;     // mid stretch
  localparam int LG    = 60;     // long stretch
  localparam int FH    = 4;      // fast half period
  localparam int SL    = 16;     // slow half period
  localparam int LIMIT = 20000;  // hang ceiling
  logic              clk_sys = 1'b0;
  logic              rstn    = 1'b0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [31:0]       pwdata  = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  pild_phy_s         phy     = '0;
  logic [LAMPS-1:0]  lampOut;
  logic [31:0]       rd;        // last read data
  logic              err;       // last error flag
  int                errCount   = 0;
  int                checksDone = 0;
  int                cycles     = 0;

  // core clock
  always #5 clk_sys = ~clk_sys;

  pild_lamp_driver #(
    .STR_SHORT(pild_cnt_t'(SH)), .STR_MID(pild_cnt_t'(MD)),
    .STR_LONG(pild_cnt_t'(LG)), .FAST_HALF(pild_cnt_t'(FH)),
    .SLOW_HALF(pild_cnt_t'(SL))
  ) dut (
    .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phyIn(phy), .lampOut(lampOut)
  );

  pild_lamp_model lamps (
    .clk_sys(clk_sys), .rstn(rstn), .lampOut(lampOut)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  // verdict and end of run
  task automatic endSim();
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // compare one value
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // wait for ready; only the hang guard ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // write the configuration word
  task automatic setCfg(input logic [3:0] a, input logic [3:0] b,
                        input logic [3:0] c, input logic [1:0] len,
                        input logic en);
    apb(1'b1, CFG_OFFSET, {16'h0000, a, b, c, len, en, 1'b0});
  endtask

  // one-cycle event on the chosen phy bits
  task automatic pulse(input logic [6:0] m);
    phy <= pild_phy_s'(phy | m);
    @(posedge clk_sys);
    phy <= pild_phy_s'(phy & ~m);
    @(posedge clk_sys);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // reset value, read-back, unmapped place
  task automatic tRegs();
    apb(1'b0, CFG_OFFSET, 32'h0);
    check("cfg reset", rd, 32'h0000_0422);
    apb(1'b1, CFG_OFFSET, 32'hFFFF_5A5B);
    apb(1'b1, 12'h018, 32'h0000_1234);
    check("unmapped write err", 32'(err), 32'h1);
    apb(1'b0, 12'h018, 32'h0);
    check("unmapped read", {rd[30:0], err}, 32'h0000_0001);
    apb(1'b0, CFG_OFFSET, 32'h0);
    check("cfg readback", {rd[30:0], err}, 32'h0000_B4B6);
  endtask

  // continuous, forced and reserved codes on all lamps
  task automatic tLevel();
    logic [3:0] codes [7] = '{4'h0, 4'h4, 4'h5, 4'h8, 4'h9, 4'h6, 4'hF};
    logic [6:0] pats [2] = '{7'h60, 7'h16};
    logic e;
    foreach (codes[i]) begin
      foreach (pats[j]) begin
        setCfg(codes[i], codes[i], codes[i], 2'b00, 1'b1);
        phy <= pild_phy_s'(pats[j]);
        repeat (6) @(posedge clk_sys);
        case (codes[i])
          4'h0: e = pats[j][5];  // speed
          4'h4: e = pats[j][6];  // link
          4'h5: e = pats[j][4];  // duplex
          4'h8: e = 1'b1;        // forced on
          default: e = 1'b0;     // off and reserved
        endcase
        check("level lamps", 32'(lampOut), {29'h0, {3{e}}});
      end
    end
  endtask

  // stretched events at every length, restart, disabled
  task automatic tStretch();
    int lens [3] = '{SH, MD, LG};
    for (int k = 0; k < 3; k++) begin
      // quiet the phy first so no stale activity reaches the new codes
      phy <= '0;
      setCfg(4'h1, 4'h2, 4'h3, 2'(k), 1'b1);
      repeat (4) @(posedge clk_sys);
      pulse(7'h0E);
      repeat (lens[k] + 20) @(posedge clk_sys);
      for (int i = 0; i < 3; i++) begin
        check("stretch run", 32'(lamps.lastLit[i] >= lens[k] &&
              lamps.lastLit[i] <= lens[k] + 3), 32'h1);
      end
    end
    setCfg(4'h7, 4'h3, 4'h1, 2'b00, 1'b1);
    pulse(7'h0C);
    repeat (8) @(posedge clk_sys);
    pulse(7'h0C);
    repeat (SH + 20) @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      check("restart run", 32'(lamps.lastLit[i] >= SH + 10 &&
            lamps.lastLit[i] <= SH + 14), 32'h1);
    end
    setCfg(4'h1, 4'h2, 4'h7, 2'b10, 1'b0);
    pulse(7'h06);
    repeat (10) @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      check("raw run", 32'(lamps.lastLit[i] >= 1 &&
            lamps.lastLit[i] <= 2), 32'h1);
    end
  endtask

  // combined codes, stretching switched off
  task automatic tCombined();
    logic [3:0] cc [5] = '{4'hC, 4'hC, 4'hD, 4'hD, 4'hE};
    logic [6:0] pm [5] = '{7'h40, 7'h40, 7'h40, 7'h40, 7'h10};
    logic [6:0] ev [5] = '{7'h02, 7'h01, 7'h04, 7'h02, 7'h08};
    foreach (cc[i]) begin
      setCfg(cc[i], cc[i], cc[i], 2'b00, 1'b0);
      phy <= pild_phy_s'(pm[i]);
      repeat (8) @(posedge clk_sys);
      check("primary solid", 32'(lampOut), 32'h7);
      pulse(ev[i]);
      repeat (SH + 20) @(posedge clk_sys);
      check("toggle run", 32'(lamps.lastDark[1] >= SH &&
            lamps.lastDark[1] <= SH + 3), 32'h1);
      check("primary back", 32'(lampOut), 32'h7);
    end
  endtask

  // fast and slow test blinking
  task automatic tBlink();
    int r0;
    int r1;
    setCfg(4'hA, 4'hB, 4'hA, 2'b00, 1'b1);
    phy <= '0;
    repeat (8) @(posedge clk_sys);
    r0 = lamps.riseCnt[0];
    r1 = lamps.riseCnt[1];
    repeat (256) @(posedge clk_sys);
    r0 = lamps.riseCnt[0] - r0;
    r1 = lamps.riseCnt[1] - r1;
    check("fast blinks", 32'(r0 >= 31 && r0 <= 33), 32'h1);
    check("slow blinks", 32'(r1 >= 7 && r1 <= 9), 32'h1);
  endtask

  // ****************************************
  // main sequence and hang guard
  // ****************************************
  // cut a hang short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errCount++;
      endSim();
    end
  end

  // reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    tRegs();
    tLevel();
    tStretch();
    tCombined();
    tBlink();
    endSim();
  end
endmodule // pild_lamp_driver_tb
`default_nettype wire

// ===== verification/pild_lamp_model.sv
// lamp model: three indicator lamps on the driver outputs
// assumes one core clock and an active-low asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module pild_lamp_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [2:0] lampOut
);
  // ****************************************
  // run records per lamp
  // ****************************************
  int litRun   [3];  // current lit run
  int darkRun  [3];  // current dark run
  int lastLit  [3];  // last finished lit run
  int lastDark [3];  // last finished dark run
  int riseCnt  [3];  // turn-on count

  // measure every lamp's on and off stretches
  always @(posedge clk_sys or negedge rstn) begin
    for (int i = 0; i < 3; i++) begin
      if (!rstn) begin
        litRun[i]   <= 0;
        darkRun[i]  <= 0;
        lastLit[i]  <= 0;
        lastDark[i] <= 0;
        riseCnt[i]  <= 0;
      end else if (lampOut[i] === 1'b1) begin
        // lamp lit: close any dark run
        if (darkRun[i] != 0) begin
          lastDark[i] <= darkRun[i];
          riseCnt[i]  <= riseCnt[i] + 1;
        end
        darkRun[i] <= 0;
        litRun[i]  <= litRun[i] + 1;
      end else begin
        // lamp dark: close any lit run
        if (litRun[i] != 0) begin
          lastLit[i] <= litRun[i];
        end
        litRun[i]  <= 0;
        darkRun[i] <= darkRun[i] + 1;
      end
    end
  end
endmodule // pild_lamp_model
`default_nettype wire
